// *** hdl/scfh_dev_end.sv ***
// device end: switching clock fault reaction and spread modulation control
`timescale 1ns/100ps
`include "scfh_params.svh"
// Overview of operation
// - second_buck clock fault: flag, disable, safe, count, irq
// - second_buck undervoltage reset source moves safe to reset
// - second_buck restarts after restart level and good clocks
// - second_buck restart followed by self test, reset extended
// - failed self test back to safe; threshold gives off
// - mcu may turn off a faulty clock monitor
// - second_buck ramp timeout in reset gives off
// - no second_buck reset source: stay safe, mcu restarts
// - boost clock fault: flag, disable, safe, count, irq
// - boost undervoltage reset source, restart when clock good
// - boost restart followed by self test, reset extended
// - boost ramp timeout in reset gives off
// - no boost reset source: stay safe, mcu restarts
// - mcu may run clock monitor diagnostic in safe
// - two factory spread modes, external or internal
// - sync steps 50 us apart, at most 100 kHz
// - external mode starts on vco, sync after reset
// - internal spread 1.79 to 2.398 MHz, 2.1 centre
// - spread within 17 percent, monitor warns beyond
// - internal spread off at power-up, enabled in diagnostic
// - spread cleared in diagnostic or off, kept in reset
// - reset entry clears sync monitor enable
module scfh_dev_end #(
	parameter int RST_TIMEOUT_CYC = `SCFH_RST_TIMEOUT_CYC
) (
	input wire logic mclk,
	input wire logic rst_b,
	scfh_link_if.dev link,
	input wire scfh_pkg::scfh_mod_t mod_mode_strap,
	input wire logic osc_good,
	input wire logic second_buck_clk_err,
	input wire logic boost_clk_err,
	input wire logic pll_clk_good,
	input wire logic second_buck_uv,
	input wire logic boost_uv,
	input wire logic second_buck_below_restart,
	input wire logic boost_below_restart,
	input wire logic second_buck_uv_rst_en,
	input wire logic boost_uv_rst_en,
	input wire logic other_rst_cond,
	input wire logic analog_self_test_fail,
	input wire logic diag_done,
	input wire logic [`SCFH_ERRCNT_W-1:0] err_thr,
	input wire logic [11:0] clk_meas_khz,
	output logic second_buck_switch_clock_fault,
	output logic boost_switch_clock_fault,
	output logic second_buck_en,
	output logic boost_en,
	output logic spread_on,
	output logic [11:0] spread_freq_khz,
	output logic clk_warn,
	output logic [`SCFH_ERRCNT_W-1:0] err_cnt,
	output scfh_pkg::scfh_state_t state
);
	import scfh_pkg::*;
	localparam int ANALOG_SELF_TEST_CYC = `SCFH_ANALOG_SELF_TEST_CYC;
	localparam int EXT_CYC = `SCFH_MCU_RESET_OUT_EXT_CYC;
	localparam logic [11:0] F_MIN = 12'(`SCFH_SPREAD_MIN_KHZ);
	localparam logic [11:0] F_MAX = 12'(`SCFH_SPREAD_MAX_KHZ);
	localparam logic [11:0] F_CTR = 12'(`SCFH_SPREAD_CTR_KHZ);
	localparam logic [23:0] PCT = 24'(`SCFH_SPREAD_PCT);

	// outside window of nominal +/- pct, done in integer kHz
	function automatic logic out_of_band(input logic [11:0] f);
		logic [23:0] dev_k;
		dev_k = (f > F_CTR) ? 24'(f - F_CTR) : 24'(F_CTR - f);
		out_of_band = (dev_k * 24'd100) > (24'(F_CTR) * PCT);
	endfunction

	scfh_state_t st_r, st_nxt;
	logic b2f_r, b2f_nxt, bof_r, bof_nxt, b2en_r, b2en_nxt, boen_r, boen_nxt;
	logic irq_r, irq_nxt, mcu_reset_out_r, mcu_reset_out_nxt, ssm_r, ssm_nxt, mon_r, mon_nxt;
	logic warn_r, warn_nxt, cmon_off_r, cmon_off_nxt, dfail_r, dfail_nxt;
	logic [`SCFH_ERRCNT_W-1:0] cnt_r, cnt_nxt;
	logic [31:0] tmo_r, tmo_nxt;
	logic [15:0] seq_r, seq_nxt, lfsr_r, lfsr_nxt;
	logic [11:0] frq_r, frq_nxt;
	logic analog_self_test_run_r, analog_self_test_run_nxt;
	logic b2_fault, bo_fault, rst_cond, bump;

	assign second_buck_switch_clock_fault = b2f_r;
	assign boost_switch_clock_fault = bof_r;
	assign second_buck_en = b2en_r;
	assign boost_en = boen_r;
	assign spread_on = ssm_r;
	assign spread_freq_khz = frq_r;
	assign clk_warn = warn_r;
	assign err_cnt = cnt_r;
	assign state = st_r;
	assign link.enable_irq_out_pin = irq_r;
	assign link.mcu_reset_out = mcu_reset_out_r;
	assign link.sync_monitor_on = mon_r;
	assign link.dev_state = st_r;
	assign link.clk_diag_fail = dfail_r;

	always_comb begin
		st_nxt = st_r;
		b2f_nxt = b2f_r;
		bof_nxt = bof_r;
		b2en_nxt = b2en_r;
		boen_nxt = boen_r;
		irq_nxt = irq_r;
		mcu_reset_out_nxt = mcu_reset_out_r;
		ssm_nxt = ssm_r;
		mon_nxt = mon_r;
		cnt_nxt = cnt_r;
		tmo_nxt = tmo_r;
		seq_nxt = seq_r;
		analog_self_test_run_nxt = analog_self_test_run_r;
		cmon_off_nxt = cmon_off_r | link.clk_mon_off;
		dfail_nxt = dfail_r;
		bump = 1'b0;
		b2_fault = second_buck_clk_err && osc_good && !cmon_off_r && st_r != SCFH_ST_OFF;
		bo_fault = boost_clk_err && osc_good && !cmon_off_r && st_r != SCFH_ST_OFF;
		rst_cond = other_rst_cond || (second_buck_uv_rst_en && second_buck_uv)
			|| (boost_uv_rst_en && boost_uv);
		// clock monitor self check answered in safe
		if (link.clk_diag_req && st_r == SCFH_ST_SAFE) begin
			dfail_nxt = !pll_clk_good || (second_buck_clk_err && boost_clk_err);
		end
		if (link.sync_monitor_on_set && st_r == SCFH_ST_DIAG) begin
			mon_nxt = 1'b1;
		end
		if (link.spread_on_wr && st_r == SCFH_ST_DIAG && mod_mode_strap == SCFH_MOD_INT) begin
			ssm_nxt = link.spread_on_val;
		end
		case (st_r)
			SCFH_ST_OFF: begin
				mcu_reset_out_nxt = 1'b0;
				b2en_nxt = 1'b0;
				boen_nxt = 1'b0;
				ssm_nxt = 1'b0;
			end
			SCFH_ST_SAFE: begin
				if (link.second_buck_on_set) begin
					b2en_nxt = 1'b1;
				end
				if (link.boost_on_set) begin
					boen_nxt = 1'b1;
				end
				if ((second_buck_uv_rst_en && second_buck_uv) || (boost_uv_rst_en && boost_uv)) begin
					st_nxt = SCFH_ST_RESET;
				end
			end
			SCFH_ST_RESET: begin
				if (tmo_r != 32'h0) begin
					tmo_nxt = tmo_r - 32'h1;
				end
				if (!b2en_r && second_buck_below_restart && pll_clk_good && !second_buck_clk_err) begin
					b2en_nxt = 1'b1;
				end
				if (!boen_r && boost_below_restart && !boost_clk_err) begin
					boen_nxt = 1'b1;
				end
				if (tmo_r == 32'h1 && rst_cond) begin
					st_nxt = SCFH_ST_OFF;
				end else if (!rst_cond && b2en_r && boen_r) begin
					// self test runs while mcu_reset_out is held low
					if (!analog_self_test_run_r) begin
						analog_self_test_run_nxt = 1'b1;
						seq_nxt = 16'(ANALOG_SELF_TEST_CYC + EXT_CYC);
					end else if (analog_self_test_fail) begin
						analog_self_test_run_nxt = 1'b0;
						st_nxt = SCFH_ST_SAFE;
						bump = 1'b1;
					end else if (seq_r != 16'h0) begin
						seq_nxt = seq_r - 16'h1;
					end else begin
						analog_self_test_run_nxt = 1'b0;
						st_nxt = SCFH_ST_DIAG;
						mcu_reset_out_nxt = 1'b1;
						irq_nxt = 1'b1;
					end
				end
			end
			SCFH_ST_DIAG: begin
				if (diag_done) begin
					st_nxt = SCFH_ST_ACTIVE;
				end
			end
			default: begin
			end
		endcase
		if (b2_fault) begin
			b2f_nxt = 1'b1;
			b2en_nxt = 1'b0;
		end
		if (bo_fault) begin
			bof_nxt = 1'b1;
			boen_nxt = 1'b0;
		end
		if (b2_fault || bo_fault) begin
			st_nxt = SCFH_ST_SAFE;
			irq_nxt = 1'b0;
			analog_self_test_run_nxt = 1'b0;
			bump = 1'b1;
		end
		if (bump) begin
			if (cnt_r != {`SCFH_ERRCNT_W{1'b1}}) begin
				cnt_nxt = cnt_r + 1'b1;
			end
			if (cnt_r + 1'b1 >= err_thr) begin
				st_nxt = SCFH_ST_OFF;
			end
		end
		// entering reset: restart the timer and drop the sync monitor
		if (st_nxt == SCFH_ST_RESET && st_r != SCFH_ST_RESET) begin
			tmo_nxt = 32'(RST_TIMEOUT_CYC);
			mon_nxt = 1'b0;
			mcu_reset_out_nxt = 1'b0;
			analog_self_test_run_nxt = 1'b0;
		end
	end

	// random spread: lfsr picks a frequency inside the allowed band
	always_comb begin
		lfsr_nxt = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		frq_nxt = F_CTR;
		if (ssm_r && mod_mode_strap == SCFH_MOD_INT) begin
			frq_nxt = F_MIN + {2'b00, lfsr_r[9:0]};
			if (frq_nxt > F_MAX) begin
				frq_nxt = F_MAX;
			end
		end
		// vco free-runs until the sync clock is supplied
		if (mod_mode_strap == SCFH_MOD_EXT && !mon_r) begin
			frq_nxt = F_CTR;
		end
		warn_nxt = out_of_band(clk_meas_khz);
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= SCFH_ST_RESET;
			b2f_r <= 1'b0;
			bof_r <= 1'b0;
			b2en_r <= 1'b0;
			boen_r <= 1'b0;
			irq_r <= 1'b1;
			mcu_reset_out_r <= 1'b0;
			ssm_r <= 1'b0;
			mon_r <= 1'b0;
			cnt_r <= '0;
			tmo_r <= 32'(RST_TIMEOUT_CYC);
			seq_r <= 16'h0;
			analog_self_test_run_r <= 1'b0;
			cmon_off_r <= 1'b0;
			dfail_r <= 1'b0;
			lfsr_r <= `SCFH_LFSR_SEED;
			frq_r <= F_CTR;
			warn_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			b2f_r <= b2f_nxt;
			bof_r <= bof_nxt;
			b2en_r <= b2en_nxt;
			boen_r <= boen_nxt;
			irq_r <= irq_nxt;
			mcu_reset_out_r <= mcu_reset_out_nxt;
			ssm_r <= ssm_nxt;
			mon_r <= mon_nxt;
			cnt_r <= cnt_nxt;
			tmo_r <= tmo_nxt;
			seq_r <= seq_nxt;
			analog_self_test_run_r <= analog_self_test_run_nxt;
			cmon_off_r <= cmon_off_nxt;
			dfail_r <= dfail_nxt;
			lfsr_r <= lfsr_nxt;
			frq_r <= frq_nxt;
			warn_r <= warn_nxt;
		end
	end
endmodule

// *** hdl/scfh_params.svh ***
// constants for the switching clock fault handler
`ifndef SCFH_PARAMS_SVH
`define SCFH_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define SCFH_CLK_MHZ 25
`define SCFH_RST_TIMEOUT_US 10000
`define SCFH_RST_TIMEOUT_CYC (`SCFH_RST_TIMEOUT_US * `SCFH_CLK_MHZ)
`define SCFH_ANALOG_SELF_TEST_CYC 64
`define SCFH_MCU_RESET_OUT_EXT_CYC 256
`define SCFH_SYNC_STEP_US 50
`define SCFH_SYNC_STEP_CYC (`SCFH_SYNC_STEP_US * `SCFH_CLK_MHZ)
// ----------------------------------------
// spread figures in kHz and percent
// ----------------------------------------
`define SCFH_SPREAD_MIN_KHZ 1790
`define SCFH_SPREAD_MAX_KHZ 2398
`define SCFH_SPREAD_CTR_KHZ 2100
`define SCFH_SYNC_STEP_KHZ 100
`define SCFH_SPREAD_PCT 17
// ----------------------------------------
// error counter and reset values
// ----------------------------------------
`define SCFH_ERRCNT_W 4
`define SCFH_ERR_THR_RST 4'h7
`define SCFH_LFSR_SEED 16'hace1
`endif

// *** hdl/scfh_pkg.sv ***
// types shared by both ends of the switching clock fault handler
package scfh_pkg;
	typedef enum logic [2:0] {
		SCFH_ST_OFF,
		SCFH_ST_RESET,
		SCFH_ST_DIAG,
		SCFH_ST_ACTIVE,
		SCFH_ST_SAFE
	} scfh_state_t;
	typedef enum logic [1:0] {
		SCFH_MOD_NONE,
		SCFH_MOD_EXT,
		SCFH_MOD_INT
	} scfh_mod_t;
endpackage

// *** hdl/scfh_link_if.sv ***
// link between the device and the microcontroller
`timescale 1ns/100ps
interface scfh_link_if;
	import scfh_pkg::*;
	logic sync_clk;
	logic sync_monitor_on_set;
	logic sync_monitor_on;
	logic second_buck_on_set;
	logic boost_on_set;
	logic spread_on_wr;
	logic spread_on_val;
	logic clk_diag_req;
	logic clk_diag_fail;
	logic clk_mon_off;
	logic enable_irq_out_pin;
	logic mcu_reset_out;
	scfh_state_t dev_state;
	modport dev (
		input sync_clk, sync_monitor_on_set, second_buck_on_set, boost_on_set,
		input spread_on_wr, spread_on_val, clk_diag_req, clk_mon_off,
		output sync_monitor_on, clk_diag_fail, enable_irq_out_pin, mcu_reset_out, dev_state
	);
	modport mcu (
		output sync_clk, sync_monitor_on_set, second_buck_on_set, boost_on_set,
		output spread_on_wr, spread_on_val, clk_diag_req, clk_mon_off,
		input sync_monitor_on, clk_diag_fail, enable_irq_out_pin, mcu_reset_out, dev_state
	);
endinterface

// *** hdl/scfh_mcu_end.sv ***
// microcontroller end: sync clock source and control commands
`timescale 1ns/100ps
`include "scfh_params.svh"
module scfh_mcu_end (
	input wire logic mclk,
	input wire logic rst_b,
	scfh_link_if.mcu link,
	input wire logic ext_mod_sel,
	input wire logic [1:0] sync_div_req,
	input wire logic buck_restart_req,
	input wire logic boost_restart_req,
	input wire logic spread_req,
	input wire logic spread_val_req,
	input wire logic diag_req,
	output logic fault_seen
);
	import scfh_pkg::*;
	localparam logic [15:0] STEP_CYC = 16'(`SCFH_SYNC_STEP_CYC);
	logic [15:0] step_cnt_r, step_cnt_nxt;
	logic [1:0] div_r, div_nxt;
	logic [2:0] ph_r, ph_nxt;
	logic sclk_r, sclk_nxt, drive_r, drive_nxt, mon_set_r, mon_set_nxt;
	logic bk_r, bk_nxt, bo_r, bo_nxt, sw_r, sw_nxt, sv_r, sv_nxt;
	logic dg_r, dg_nxt, off_r, off_nxt, seen_r, seen_nxt, mcu_reset_out_d_r, mcu_reset_out_d_nxt;
	logic diag_pend_r, diag_pend_nxt;

	assign link.sync_clk = sclk_r;
	assign link.sync_monitor_on_set = mon_set_r;
	assign link.second_buck_on_set = bk_r;
	assign link.boost_on_set = bo_r;
	assign link.spread_on_wr = sw_r;
	assign link.spread_on_val = sv_r;
	assign link.clk_diag_req = dg_r;
	assign link.clk_mon_off = off_r;
	assign fault_seen = seen_r;

	always_comb begin
		step_cnt_nxt = step_cnt_r;
		div_nxt = div_r;
		ph_nxt = ph_r + 3'h1;
		sclk_nxt = sclk_r;
		drive_nxt = drive_r;
		mon_set_nxt = 1'b0;
		mcu_reset_out_d_nxt = link.mcu_reset_out;
		seen_nxt = ~link.enable_irq_out_pin;
		// drive the sync clock only after the device lets the mcu out of reset
		if (!link.mcu_reset_out) begin
			drive_nxt = 1'b0;
		end else if (ext_mod_sel && !mcu_reset_out_d_r) begin
			drive_nxt = 1'b1;
		end
		// re-arm the sync monitor one cycle after driving has resumed
		if (drive_r && link.dev_state == SCFH_ST_DIAG && !link.sync_monitor_on) begin
			mon_set_nxt = 1'b1;
		end
		// frequency steps are spaced and limited to one divider code each
		if (step_cnt_r != 16'h0) begin
			step_cnt_nxt = step_cnt_r - 16'h1;
		end else if (sync_div_req != div_r) begin
			div_nxt = (sync_div_req > div_r) ? div_r + 2'h1 : div_r - 2'h1;
			step_cnt_nxt = STEP_CYC;
		end
		if (drive_r && ph_r >= {1'b0, div_r} + 3'h1) begin
			ph_nxt = 3'h0;
			sclk_nxt = ~sclk_r;
		end
		if (!drive_r) begin
			sclk_nxt = 1'b0;
		end
		bk_nxt = buck_restart_req && link.dev_state == SCFH_ST_SAFE;
		bo_nxt = boost_restart_req && link.dev_state == SCFH_ST_SAFE;
		sw_nxt = spread_req && link.dev_state == SCFH_ST_DIAG;
		sv_nxt = spread_val_req;
		dg_nxt = diag_req && link.dev_state == SCFH_ST_SAFE;
		diag_pend_nxt = diag_pend_r;
		off_nxt = off_r;
		if (dg_r) begin
			diag_pend_nxt = 1'b1;
		end else if (diag_pend_r) begin
			diag_pend_nxt = 1'b0;
			// a failed monitor is a single-point, non-critical fault
			if (link.clk_diag_fail && link.dev_state == SCFH_ST_SAFE) begin
				off_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			step_cnt_r <= 16'h0;
			div_r <= 2'h0;
			ph_r <= 3'h0;
			sclk_r <= 1'b0;
			drive_r <= 1'b0;
			mon_set_r <= 1'b0;
			bk_r <= 1'b0;
			bo_r <= 1'b0;
			sw_r <= 1'b0;
			sv_r <= 1'b0;
			dg_r <= 1'b0;
			off_r <= 1'b0;
			seen_r <= 1'b0;
			mcu_reset_out_d_r <= 1'b0;
			diag_pend_r <= 1'b0;
		end else begin
			step_cnt_r <= step_cnt_nxt;
			div_r <= div_nxt;
			ph_r <= ph_nxt;
			sclk_r <= sclk_nxt;
			drive_r <= drive_nxt;
			mon_set_r <= mon_set_nxt;
			bk_r <= bk_nxt;
			bo_r <= bo_nxt;
			sw_r <= sw_nxt;
			sv_r <= sv_nxt;
			dg_r <= dg_nxt;
			off_r <= off_nxt;
			seen_r <= seen_nxt;
			mcu_reset_out_d_r <= mcu_reset_out_d_nxt;
			diag_pend_r <= diag_pend_nxt;
		end
	end
endmodule

// *** tb/scfh_link_sva.sv ***
// assertion checker for the clock fault link
`timescale 1ns/100ps
`include "scfh_params.svh"
module scfh_link_sva #(
	parameter int TMO = 200
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic sync_monitor_on,
	input wire logic enable_irq_out_pin,
	input wire logic mcu_reset_out,
	input wire scfh_pkg::scfh_state_t dev_state
);
	import scfh_pkg::*;
	localparam int EXT_MIN = `SCFH_ANALOG_SELF_TEST_CYC + `SCFH_MCU_RESET_OUT_EXT_CYC;
	int rst_cnt_r;
	int rst_cnt_nxt;
	// ----------------------------------------
	// cycles spent in reset, to bound the exit time
	// ----------------------------------------
	always_comb begin
		rst_cnt_nxt = (dev_state == SCFH_ST_RESET) ? rst_cnt_r + 1 : 0;
	end
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_cnt_r <= 0;
		end else begin
			rst_cnt_r <= rst_cnt_nxt;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	sequence s_rst_entry;
		dev_state == SCFH_ST_RESET && $past(dev_state) != SCFH_ST_RESET;
	endsequence
	sequence s_diag_entry;
		dev_state == SCFH_ST_DIAG && $past(dev_state) == SCFH_ST_RESET;
	endsequence
	property p_rst_sync_off;
		s_rst_entry |-> !sync_monitor_on;
	endproperty
	a_rst_sync_off: assert property (p_rst_sync_off) else $error("sync monitor on in reset");
	property p_sync_on_diag;
		$rose(sync_monitor_on) |-> $past(dev_state) == SCFH_ST_DIAG;
	endproperty
	a_sync_on_diag: assert property (p_sync_on_diag) else $error("sync monitor set out of diag");
	property p_safe_irq;
		dev_state == SCFH_ST_SAFE && $past(dev_state) inside {SCFH_ST_DIAG, SCFH_ST_ACTIVE}
			|-> !enable_irq_out_pin;
	endproperty
	a_safe_irq: assert property (p_safe_irq) else $error("safe entry without irq");
	property p_rst_mcu_reset_out;
		dev_state == SCFH_ST_RESET |-> !mcu_reset_out;
	endproperty
	a_rst_mcu_reset_out: assert property (p_rst_mcu_reset_out) else $error("reset out high in reset");
	property p_mcu_reset_out_rise;
		$rose(mcu_reset_out) |-> s_diag_entry ##0 enable_irq_out_pin;
	endproperty
	a_mcu_reset_out_rise: assert property (p_mcu_reset_out_rise) else $error("reset out rose badly");
	property p_off_hold;
		dev_state == SCFH_ST_OFF |=> dev_state == SCFH_ST_OFF;
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("left off state");
	property p_ext_len;
		s_diag_entry |-> rst_cnt_r >= EXT_MIN;
	endproperty
	a_ext_len: assert property (p_ext_len) else $error("reset extension too short");
	property p_tmo;
		dev_state == SCFH_ST_RESET |-> rst_cnt_r <= TMO + 330;
	endproperty
	a_tmo: assert property (p_tmo) else $error("reset outlived its timeout");
endmodule

// *** tb/tb.sv ***
// self-checking bench for both ends of the clock fault link
`timescale 1ns/100ps
module tb;
	import scfh_pkg::*;
	localparam int TMO = 200;
	logic mclk, rst_b = 1'b0, osc_good = 1'b1, pll_clk_good = 1'b1, ext_mod_sel = 1'b1;
	logic second_buck_clk_err = 1'b0, boost_clk_err = 1'b0, second_buck_uv = 1'b0, boost_uv = 1'b0;
	logic second_buck_below_restart = 1'b1, boost_below_restart = 1'b1, diag_done = 1'b0;
	logic second_buck_uv_rst_en = 1'b0, boost_uv_rst_en = 1'b0, other_rst_cond = 1'b0;
	logic analog_self_test_fail = 1'b0, buck_restart_req = 1'b0, boost_restart_req = 1'b0;
	logic spread_req = 1'b0, spread_val_req = 1'b0, diag_req = 1'b0;
	logic second_buck_switch_clock_fault, boost_switch_clock_fault, second_buck_en, boost_en;
	logic spread_on, clk_warn, fault_seen;
	logic [1:0] sync_div_req = 2'h0;
	logic [3:0] err_thr = 4'h7;
	logic [3:0] err_cnt;
	logic [11:0] clk_meas_khz = 12'h834;
	logic [11:0] spread_freq_khz;
	scfh_mod_t mod_mode_strap = SCFH_MOD_INT;
	scfh_state_t state;
	int err_count = 0, n_checks = 0, cyc = 0;
	scfh_link_if link();
	scfh_dev_end #(.RST_TIMEOUT_CYC(TMO)) scfh_dev_end_inst (.mclk, .rst_b, .link,
		.mod_mode_strap, .osc_good, .second_buck_clk_err, .boost_clk_err, .pll_clk_good,
		.second_buck_uv, .boost_uv, .second_buck_below_restart, .boost_below_restart, .second_buck_uv_rst_en,
		.boost_uv_rst_en, .other_rst_cond, .analog_self_test_fail, .diag_done, .err_thr, .clk_meas_khz,
		.second_buck_switch_clock_fault, .boost_switch_clock_fault, .second_buck_en, .boost_en,
		.spread_on, .spread_freq_khz, .clk_warn, .err_cnt, .state);
	scfh_mcu_end scfh_mcu_end_inst (.mclk, .rst_b, .link, .ext_mod_sel, .sync_div_req,
		.buck_restart_req, .boost_restart_req, .spread_req, .spread_val_req, .diag_req,
		.fault_seen);
	scfh_link_sva #(.TMO(TMO)) scfh_link_sva_inst (.mclk, .rst_b,
		.sync_monitor_on(link.sync_monitor_on), .enable_irq_out_pin(link.enable_irq_out_pin),
		.mcu_reset_out(link.mcu_reset_out), .dev_state(link.dev_state));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// cut a hang short well beyond the expected run length
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic got, input logic exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_st(input scfh_state_t got, input scfh_state_t exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic chk_num(input logic [11:0] got, input logic [11:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic wait_st(input scfh_state_t s, input int n);
		for (int i = 0; i < n && state !== s; i++) step(1);
		chk_st(state, s, "state not reached");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_boot();
		wait_st(SCFH_ST_DIAG, 400);
		chk(link.mcu_reset_out & link.enable_irq_out_pin, 1'b1, "pins after boot");
		chk(second_buck_en & boost_en, 1'b1, "enables after boot");
		chk(spread_on, 1'b0, "spread at power-up");
		chk_num(spread_freq_khz, 12'h834, "centre frequency");
		$display("test boot done");
	endtask
	task automatic t_spread();
		spread_req = 1'b1;
		spread_val_req = 1'b1;
		step(4);
		spread_req = 1'b0;
		chk(spread_on, 1'b1, "spread on in diag");
		chk(spread_freq_khz >= 12'h6fe && spread_freq_khz <= 12'h95e, 1'b1, "range");
		// warning edge sits exactly at 2457 kHz, the last value still inside
		clk_meas_khz = 12'h999;
		step(2);
		chk(clk_warn, 1'b0, "warn at limit");
		clk_meas_khz = 12'h99a;
		step(2);
		chk(clk_warn, 1'b1, "warn past limit");
		clk_meas_khz = 12'h834;
		$display("test spread done");
	endtask
	task automatic t_buck();
		diag_done = 1'b1;
		step(1);
		diag_done = 1'b0;
		spread_val_req = 1'b0;
		spread_req = 1'b1;
		step(4);
		spread_req = 1'b0;
		chk(spread_on, 1'b1, "spread kept outside diag");
		second_buck_clk_err = 1'b1;
		step(1);
		second_buck_clk_err = 1'b0;
		chk(second_buck_switch_clock_fault, 1'b1, "buck flag");
		chk(second_buck_en | link.enable_irq_out_pin, 1'b0, "buck off, irq");
		chk_st(state, SCFH_ST_SAFE, "safe after buck fault");
		chk_num({8'h00, err_cnt}, 12'h001, "count one");
		buck_restart_req = 1'b1;
		step(3);
		buck_restart_req = 1'b0;
		chk(second_buck_en, 1'b1, "mcu restart");
		chk(fault_seen, 1'b1, "mcu saw irq");
		second_buck_uv_rst_en = 1'b1;
		second_buck_uv = 1'b1;
		step(2);
		chk_st(state, SCFH_ST_RESET, "uv reset");
		chk(link.mcu_reset_out, 1'b0, "reset out low in reset");
		chk(spread_on, 1'b1, "spread kept in reset");
		chk(link.sync_monitor_on, 1'b0, "sync monitor off");
		second_buck_uv = 1'b0;
		wait_st(SCFH_ST_DIAG, 400);
		chk(link.enable_irq_out_pin, 1'b1, "irq released");
		$display("test buck done");
	endtask
	task automatic t_boost();
		boost_clk_err = 1'b1;
		step(1);
		boost_clk_err = 1'b0;
		chk(boost_switch_clock_fault, 1'b1, "boost flag");
		chk(boost_en | link.enable_irq_out_pin, 1'b0, "boost off, irq");
		chk_num({8'h00, err_cnt}, 12'h002, "count two");
		boost_uv_rst_en = 1'b1;
		boost_uv = 1'b1;
		analog_self_test_fail = 1'b1;
		step(5);
		chk_st(state, SCFH_ST_RESET, "boost uv reset");
		chk(boost_en, 1'b1, "boost restart");
		boost_uv = 1'b0;
		wait_st(SCFH_ST_SAFE, 400);
		analog_self_test_fail = 1'b0;
		chk_num({8'h00, err_cnt}, 12'h003, "count three");
		// failed monitor self check lets the mcu switch monitoring off
		pll_clk_good = 1'b0;
		diag_req = 1'b1;
		step(2);
		diag_req = 1'b0;
		step(5);
		pll_clk_good = 1'b1;
		chk(link.clk_diag_fail, 1'b1, "diag fail reported");
		boost_clk_err = 1'b1;
		step(1);
		boost_clk_err = 1'b0;
		chk_num({8'h00, err_cnt}, 12'h003, "fault ignored, monitor off");
		chk_st(state, SCFH_ST_SAFE, "still safe, monitor off");
		other_rst_cond = 1'b1;
		boost_uv = 1'b1;
		step(2);
		boost_uv = 1'b0;
		chk_st(state, SCFH_ST_RESET, "reset again");
		step(TMO - 10);
		chk_st(state, SCFH_ST_RESET, "not yet off");
		wait_st(SCFH_ST_OFF, 20);
		step(1);
		chk(spread_on, 1'b0, "spread cleared in off");
		other_rst_cond = 1'b0;
		$display("test boost done");
	endtask
	task automatic t_thr();
		rst_b = 1'b0;
		err_thr = 4'h2;
		step(2);
		rst_b = 1'b1;
		wait_st(SCFH_ST_DIAG, 400);
		boost_clk_err = 1'b1;
		step(1);
		boost_clk_err = 1'b0;
		chk_num({8'h00, err_cnt}, 12'h001, "count after reset");
		boost_uv = 1'b1;
		analog_self_test_fail = 1'b1;
		step(2);
		boost_uv = 1'b0;
		wait_st(SCFH_ST_OFF, 400);
		$display("test threshold done");
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		t_boot();
		t_spread();
		t_buck();
		t_boost();
		t_thr();
		tally_and_finish();
	end
endmodule
